// >>> ctsr_regs.sv
// Purpose: timer, faulting address and operating state registers
// Assumes: Avalon-MM slave, word address is the register number
// Notes: answers every access one cycle after it is presented
`timescale 1ns/100ps
module ctsr_regs
  import ctsr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Fault report from pipeline
  input wire logic fault_valid,
  input wire logic fault_is_bus_error,
  input wire logic fault_is_fetch,
  input wire logic [63:0] fault_address,
  // Interrupt sources and TLB shutdown event
  input wire logic [1:0] soft_irq,
  input wire logic [4:0] ext_irq,
  input wire logic perf_irq,
  input wire logic tlb_shutdown,
  // Mode inputs
  input wire logic kernel_mode,
  input wire logic [3:0] coproc_access,
  // Decoded state
  output logic irq_request,
  output logic [3:0] coproc_unusable,
  output logic extended_isa_enable_bit,
  output logic float_register_count_select,
  output logic kernel_wide_addressing,
  output logic supervisor_wide_addressing,
  output logic [7:0] timer_pending_vec
);
  logic [31:0] free_running_counter;
  logic [31:0] timer_match_value;
  logic [31:0] processor_operating_state;
  logic [63:0] faulting_virtual_address;
  logic timer_pending_bit;
  logic tlb_shutdown_flag;
  logic count_step;
  logic answered;
  logic [4:0] word;
  logic wr_hit;
  logic [1:0] soft_s1, soft_s2;
  logic [4:0] ext_s1, ext_s2;
  logic [31:0] next_readdata;
  logic [7:0] pending;
  logic [7:0] interrupt_mask_field;
  logic [3:0] coprocessor_usable_field;
  logic [8:0] diagnostic_field;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    merge = (old & ~m) | (data & m);
  endfunction : merge

  assign word = avs_address[6:2];
  assign wr_hit = avs_write && !answered;
  assign interrupt_mask_field = processor_operating_state[IM_LSB +: IM_W];
  assign coprocessor_usable_field = processor_operating_state[CU_LSB +: 4];
  assign diagnostic_field = processor_operating_state[DS_LSB +: 9];
  assign pending = {timer_pending_bit, ext_s2, soft_s2};

  // Two stages: one access per two cycles, no back-to-back double write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      answered <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      answered <= (avs_read || avs_write) && !answered;
      avs_waitrequest <= !((avs_read || avs_write) && !answered);
    end
  end

  ctsr_counter u_counter (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(wr_hit && word == REG_COUNTER && avs_byteenable == 4'hF),
    .load_value(avs_writedata),
    .count(free_running_counter),
    .step(count_step)
  );

  ctsr_fault_capture u_fault (
    .core_clk(core_clk),
    .resetn(resetn),
    .fault_valid(fault_valid),
    .fault_is_bus_error(fault_is_bus_error),
    .fault_is_fetch(fault_is_fetch),
    .fault_address(fault_address),
    .faulting_virtual_address(faulting_virtual_address)
  );

  // External lines come from outside the clock domain
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      soft_s1 <= 2'h0;
      soft_s2 <= 2'h0;
    end else begin
      soft_s1 <= soft_irq;
      soft_s2 <= soft_s1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ext_s1 <= 5'h00;
      ext_s2 <= 5'h00;
    end else begin
      ext_s1 <= ext_irq;
      ext_s2 <= ext_s1;
    end
  end

  // Sticky until reset; software has no way to clear it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tlb_shutdown_flag <= 1'b0;
    end else begin
      tlb_shutdown_flag <= tlb_shutdown_flag | tlb_shutdown;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timer_match_value <= MATCH_RESET;
    end else if (wr_hit && word == REG_MATCH) begin
      timer_match_value <= merge(timer_match_value, avs_writedata,
                                 avs_byteenable, 32'hFFFFFFFF);
    end
  end

  // Set wins over the clear from a match write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timer_pending_bit <= 1'b0;
    end else if ((count_step && free_running_counter == timer_match_value)
                 || perf_irq) begin
      timer_pending_bit <= 1'b1;
    end else if (wr_hit && word == REG_MATCH) begin
      timer_pending_bit <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      processor_operating_state <= OPSTATE_RESET;
    end else if (wr_hit && word == REG_OPSTATE) begin
      processor_operating_state <= merge(processor_operating_state,
        avs_writedata, avs_byteenable, OPSTATE_WMASK);
    end
  end

  always_comb begin
    next_readdata = UNMAPPED_READ;
    unique case (word)
      REG_FAULT_ADDR: next_readdata = faulting_virtual_address[31:0];
      REG_FAULT_ADDR_HI: next_readdata = faulting_virtual_address[63:32];
      REG_COUNTER: next_readdata = free_running_counter;
      REG_MATCH: next_readdata = timer_match_value;
      REG_OPSTATE: begin
        next_readdata = processor_operating_state;
        next_readdata[TS_BIT] = tlb_shutdown_flag;
      end
      REG_PENDING: next_readdata = {24'h000000, pending};
      REG_SIDEBAND: next_readdata = {31'h00000000, tlb_shutdown_flag};
      default: next_readdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= UNMAPPED_READ;
    end else if (avs_read && !answered) begin
      avs_readdata <= next_readdata;
    end
  end

  // Decoded controls, registered so each output is a flip-flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= processor_operating_state[IE_BIT]
                     && |(interrupt_mask_field & pending);
    end
  end

  // Bit 0 is waived in kernel mode only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      coproc_unusable <= 4'h0;
    end else begin
      coproc_unusable <= coproc_access & ~coprocessor_usable_field
                         & {3'h7, ~kernel_mode};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extended_isa_enable_bit <= 1'b0;
    end else begin
      extended_isa_enable_bit <= coprocessor_usable_field[3];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      float_register_count_select <= 1'b0;
    end else begin
      float_register_count_select <=
        processor_operating_state[FR_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      kernel_wide_addressing <= 1'b0;
    end else begin
      kernel_wide_addressing <=
        processor_operating_state[KX_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      supervisor_wide_addressing <= 1'b0;
    end else begin
      supervisor_wide_addressing <=
        processor_operating_state[SX_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timer_pending_vec <= 8'h00;
    end else begin
      timer_pending_vec <= pending;
    end
  end

  sequence match_write_s;
    wr_hit && word == REG_MATCH;
  endsequence

  sequence no_set_s;
    !perf_irq && !(count_step && free_running_counter == timer_match_value);
  endsequence

  match_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    match_write_s and no_set_s |=> !timer_pending_bit)
    else $error("match write did not clear pending");

  match_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    count_step && free_running_counter == timer_match_value
    |=> timer_pending_bit)
    else $error("count match did not set pending");

  perf_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    perf_irq |=> timer_pending_bit)
    else $error("performance source did not set pending");

  irq_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !processor_operating_state[IE_BIT] |=> !irq_request)
    else $error("interrupt raised while disabled");

  irq_mask_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (interrupt_mask_field & pending) == 8'h00 |=> !irq_request)
    else $error("masked source raised interrupt");

  cp0_kernel_a: assert property (@(posedge core_clk) disable iff (!resetn)
    kernel_mode |=> !coproc_unusable[0])
    else $error("system coprocessor refused in kernel");

  reserved_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_hit && word == REG_OPSTATE && avs_byteenable == 4'hF
    |=> processor_operating_state[27] == $past(avs_writedata[27])
        && processor_operating_state[25] == $past(avs_writedata[25])
        && processor_operating_state[23] == $past(avs_writedata[23])
        && processor_operating_state[19] == $past(avs_writedata[19])
        && processor_operating_state[16] == $past(avs_writedata[16]))
    else $error("reserved bit not stored");

  bus_answer_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (avs_read || avs_write) && avs_waitrequest |-> ##[0:1] !avs_waitrequest)
    else $error("bus access not answered");

  diag_store_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_hit && word == REG_OPSTATE && avs_byteenable == 4'hF
    |=> diagnostic_field == ($past(avs_writedata[DS_LSB +: 9])
                             & ~(9'h001 << (TS_BIT - DS_LSB))))
    else $error("diagnostic field not stored");

  match_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    avs_read && !answered && word == REG_MATCH
    |=> avs_readdata == $past(timer_match_value))
    else $error("match register read wrong");

  count_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    avs_read && !answered && word == REG_COUNTER
    |=> avs_readdata == $past(free_running_counter))
    else $error("counter read wrong");

  isa_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    extended_isa_enable_bit == $past(coprocessor_usable_field[3]))
    else $error("instruction set enable stale");

  fr_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    float_register_count_select == $past(processor_operating_state[FR_BIT]))
    else $error("float register select stale");

  wide_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    kernel_wide_addressing == $past(processor_operating_state[KX_BIT])
    && supervisor_wide_addressing
       == $past(processor_operating_state[SX_BIT]))
    else $error("address width select stale");

  vec_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    timer_pending_vec == $past(pending))
    else $error("pending vector stale");
endmodule : ctsr_regs

// >>> ctsr_pkg.sv
// Purpose: constants for the system-control timer and status register set
// Assumes: registers reached by register number over Avalon-MM
// Notes: byte address is four times the register number
package ctsr_pkg;
  localparam logic [4:0] REG_FAULT_ADDR = 5'h08;
  localparam logic [4:0] REG_FAULT_ADDR_HI = 5'h10;
  localparam logic [4:0] REG_COUNTER = 5'h09;
  localparam logic [4:0] REG_MATCH = 5'h0B;
  localparam logic [4:0] REG_OPSTATE = 5'h0C;
  localparam logic [4:0] REG_PENDING = 5'h0D;
  localparam logic [4:0] REG_SIDEBAND = 5'h11;
  localparam logic [6:0] ADDR_W = 7'h07;
  localparam int IM_LSB = 8;
  localparam int IM_W = 8;
  localparam int TIMER_IRQ = 7;
  localparam int CU_LSB = 28;
  localparam int FR_BIT = 26;
  localparam int DS_LSB = 16;
  localparam int TS_BIT = 21;
  localparam int KX_BIT = 7;
  localparam int SX_BIT = 6;
  localparam int IE_BIT = 0;
  // Writable bits: all but the read-only TLB shutdown flag; reserved bits
  // 27, 25, 23, 19 and 16 are plain storage
  localparam logic [31:0] OPSTATE_WMASK = 32'hFFDFFFFF;
  localparam logic [31:0] OPSTATE_RESET = 32'h00010000;
  localparam logic [31:0] COUNTER_RESET = 32'h00000000;
  localparam logic [31:0] MATCH_RESET = 32'hFFFFFFFF;
  localparam logic [63:0] FAULT_RESET = 64'h0000000000000000;
  localparam logic [63:0] IFETCH_MASK = 64'h07FFFF0000000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  localparam logic TICK_RESET = 1'b0;
endpackage : ctsr_pkg

// >>> ctsr_counter.sv
// Purpose: free-running counter at half the pipeline clock rate
// Assumes: one clock, tick toggles every cycle
// Notes: a load restarts nothing but the value
`timescale 1ns/100ps
module ctsr_counter
  import ctsr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Load
  input wire logic load,
  input wire logic [31:0] load_value,
  // State
  output logic [31:0] count,
  output logic step
);
  logic tick;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tick <= TICK_RESET;
    end else begin
      tick <= ~tick;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= COUNTER_RESET;
      step <= 1'b0;
    end else begin
      step <= tick & ~load;
      if (load) begin
        count <= load_value;
      end else if (tick) begin
        count <= count + 32'h00000001;
      end
    end
  end

  count_rate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !load && !$past(load) && $past(tick) |-> count != $past(count))
    else $error("counter missed a tick");

  count_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(!load) && !$past(tick) |-> count == $past(count))
    else $error("counter moved off tick");
endmodule : ctsr_counter

// >>> ctsr_fault_capture.sv
// Purpose: faulting address capture
// Assumes: fault strobe is one cycle wide from pipeline logic
// Notes: bus errors never update the address
`timescale 1ns/100ps
module ctsr_fault_capture
  import ctsr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Fault report
  input wire logic fault_valid,
  input wire logic fault_is_bus_error,
  input wire logic fault_is_fetch,
  input wire logic [63:0] fault_address,
  // Captured address
  output logic [63:0] faulting_virtual_address
);
  function automatic logic [63:0] fill_fetch(input logic [63:0] a);
    // Fill bits 58:40 from bit 39, as a sign extension
    fill_fetch = (a & ~IFETCH_MASK) | ({64{a[39]}} & IFETCH_MASK);
  endfunction : fill_fetch

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      faulting_virtual_address <= FAULT_RESET;
    end else if (fault_valid && !fault_is_bus_error) begin
      faulting_virtual_address <= fault_is_fetch ?
        fill_fetch(fault_address) : fault_address;
    end
  end

  bus_err_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_valid && fault_is_bus_error |=> $stable(faulting_virtual_address))
    else $error("bus error changed fault address");

  capture_data_a: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_valid && !fault_is_bus_error && !fault_is_fetch
    |=> faulting_virtual_address == $past(fault_address))
    else $error("data fault address not captured");
endmodule : ctsr_fault_capture

// >>> ctsr_pipe_model.sv
// Purpose: pipeline model that reaches the registers and reports faults
// Assumes: one request at a time, called from the bench
// Notes: released lines show inverted data so stale values never match
`timescale 1ns/100ps
module ctsr_pipe_model (
  // Clock
  input wire logic core_clk,
  // Avalon-MM master
  output logic [6:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Fault report
  output logic fault_valid,
  output logic fault_is_bus_error,
  output logic fault_is_fetch,
  output logic [63:0] fault_address
);
  initial begin
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    fault_valid = 1'b0;
    fault_is_bus_error = 1'b0;
    fault_is_fetch = 1'b0;
    fault_address = 64'h0000000000000000;
  end

  task automatic access(input logic is_rd, input logic [4:0] regn,
                        input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge core_clk);
    avs_address <= {regn, 2'b00};
    avs_read <= is_rd;
    avs_write <= ~is_rd;
    avs_writedata <= wd;
    // Hold until the slave lets go; the bench timeout ends a hang
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~{regn, 2'b00};
    avs_writedata <= ~wd;
  endtask : access

  task automatic fault(input logic bus_err, input logic fetch,
                       input logic [63:0] a);
    @(posedge core_clk);
    fault_valid <= 1'b1;
    fault_is_bus_error <= bus_err;
    fault_is_fetch <= fetch;
    fault_address <= a;
    @(posedge core_clk);
    fault_valid <= 1'b0;
    fault_address <= ~a;
  endtask : fault
endmodule : ctsr_pipe_model

// >>> test_cp0_timer_status_regs.sv
// Purpose: self-checking bench for the timer and status registers
// Assumes: pipeline model drives bus and fault reports
// Notes: expectations come from the rules, not from the design
`timescale 1ns/100ps
module test_cp0_timer_status_regs;
  import ctsr_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] be = 4'hF;
  logic fault_valid, fault_is_bus_error, fault_is_fetch;
  logic [63:0] fault_address;
  logic [1:0] soft_irq = 2'h0;
  logic [4:0] ext_irq = 5'h00;
  logic perf_irq = 1'b0;
  logic tlb_shutdown = 1'b0;
  logic kernel_mode = 1'b0;
  logic [3:0] coproc_access = 4'h0;
  logic irq_request, isa, fr, kwide, swide;
  logic [3:0] coproc_unusable;
  logic [7:0] timer_pending_vec;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  ctsr_regs i_dut (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fault_valid(fault_valid), .fault_is_bus_error(fault_is_bus_error),
    .fault_is_fetch(fault_is_fetch), .fault_address(fault_address),
    .soft_irq(soft_irq), .ext_irq(ext_irq), .perf_irq(perf_irq),
    .tlb_shutdown(tlb_shutdown), .kernel_mode(kernel_mode),
    .coproc_access(coproc_access), .irq_request(irq_request),
    .coproc_unusable(coproc_unusable), .extended_isa_enable_bit(isa),
    .float_register_count_select(fr), .kernel_wide_addressing(kwide),
    .supervisor_wide_addressing(swide),
    .timer_pending_vec(timer_pending_vec));

  ctsr_pipe_model i_pipe (.core_clk(core_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_valid(fault_valid),
    .fault_is_bus_error(fault_is_bus_error),
    .fault_is_fetch(fault_is_fetch), .fault_address(fault_address));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd(input logic [4:0] r, output logic [31:0] d);
    i_pipe.access(1'b1, r, 32'h00000000, d);
  endtask : rd

  task automatic wr(input logic [4:0] r, input logic [31:0] v);
    logic [31:0] d;
    i_pipe.access(1'b0, r, v, d);
  endtask : wr

  // Budget well above the roughly 400 cycles the tests need
  // Non-blocking so readers at the same edge see a settled count
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] d, d2, st;
    logic [63:0] fa;
    int c1;
    d = $urandom(32'h11A4);
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rd(REG_OPSTATE, d); check("status_rst", 32'h00010000, d);
    rd(REG_MATCH, d); check("match_rst", 32'hFFFFFFFF, d);
    rd(5'h03, d); check("unmapped", 32'h00000000, d);
    $display("test reset done");
    wr(REG_COUNTER, 32'h00000000);
    rd(REG_COUNTER, d); c1 = cyc;
    check("count_load", 1, d < 32'h8);
    repeat (50) @(posedge core_clk);
    rd(REG_COUNTER, d2);
    check("count_rate", 1, (d2 - d) * 2 + 1 >= cyc - c1
          && (d2 - d) * 2 <= cyc - c1 + 1);
    wr(REG_COUNTER, 32'hFFFFFFFE);
    repeat (20) @(posedge core_clk);
    rd(REG_COUNTER, d); check("count_wrap", 1, d < 32'h20);
    $display("test counter done");
    wr(REG_OPSTATE, 32'h00018001);
    wr(REG_COUNTER, 32'h00000100);
    wr(REG_MATCH, 32'h00000120);
    rd(REG_MATCH, d); check("match_hold", 32'h120, d);
    check("pend_early", 0, timer_pending_vec[7]);
    repeat (80) @(posedge core_clk);
    check("pend_set", 1, timer_pending_vec[7]);
    check("irq_timer", 1, irq_request);
    rd(REG_PENDING, d); check("pend_reg", 1, d[7]);
    wr(REG_MATCH, 32'h00000000);
    @(posedge core_clk);
    check("pend_clr", 0, timer_pending_vec[7]);
    perf_irq <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("perf_pend", 1, timer_pending_vec[7]);
    perf_irq <= 1'b0;
    wr(REG_MATCH, 32'h00000000);
    $display("test timer done");
    for (int i = 0; i < 7; i++) begin
      {ext_irq, soft_irq} <= 7'h01 << i;
      wr(REG_OPSTATE, 32'h00010001 | (32'h100 << i));
      repeat (4) @(posedge core_clk);
      check("pend_vec", 8'h01 << i, timer_pending_vec);
      check("irq_on", 1, irq_request);
      wr(REG_OPSTATE, 32'h00010000 | (32'h100 << i));
      repeat (2) @(posedge core_clk);
      check("irq_ie_off", 0, irq_request);
      wr(REG_OPSTATE, 32'h00010001 | (32'h200 << i));
      repeat (2) @(posedge core_clk);
      check("irq_masked", 0, irq_request);
    end
    {ext_irq, soft_irq} <= 7'h00;
    $display("test interrupts done");
    for (int i = 0; i < 6; i++) begin
      st = $urandom & 32'hFFFFFFFE;
      wr(REG_OPSTATE, st);
      rd(REG_OPSTATE, d);
      check("status_rw", st & 32'hFFDFFFFF, d);
      kernel_mode <= i[0];
      coproc_access <= 4'hF;
      repeat (3) @(posedge core_clk);
      check("kwide", st[7], kwide);
      check("swide", st[6], swide);
      check("fr", st[26], fr);
      check("isa", st[31], isa);
      check("cu", ~st[31:28] & {3'h7, ~i[0]}, coproc_unusable);
    end
    $display("test status done");
    fa = {$urandom, $urandom};
    i_pipe.fault(1'b0, 1'b0, fa);
    rd(REG_FAULT_ADDR, d); check("fault_lo", fa[31:0], d);
    rd(REG_FAULT_ADDR_HI, d); check("fault_hi", fa[63:32], d);
    i_pipe.fault(1'b1, 1'b0, ~fa);
    rd(REG_FAULT_ADDR_HI, d); check("fault_bus", fa[63:32], d);
    fa = {$urandom, $urandom};
    i_pipe.fault(1'b0, 1'b1, fa);
    fa[58:40] = {19{fa[39]}};
    rd(REG_FAULT_ADDR_HI, d); check("fault_ifetch", fa[63:32], d);
    $display("test fault done");
    tlb_shutdown <= 1'b1;
    @(posedge core_clk);
    tlb_shutdown <= 1'b0;
    wr(REG_OPSTATE, 32'h00010000);
    rd(REG_OPSTATE, d); check("ts_flag", 32'h00210000, d);
    $display("test shutdown flag done");
    report_and_stop();
  end
endmodule : test_cp0_timer_status_regs
